// [verilog/spi3_pkg.sv]
/*
  Constants, types and register map for the three-wire serial port.
  Assumes an 8-bit special-function-register bus on the processor side.
*/
package spi3_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_GLB_ADDR = 8'ha8; // Global enable byte
  localparam logic [7:0] IRQ_GRP_ADDR = 8'hb8; // Group enable byte
  localparam logic [7:0] CTLA_ADDR = 8'ha1; // Port control a
  localparam logic [7:0] CTLB_ADDR = 8'ha2; // Port control b
  localparam logic [7:0] RATE_ADDR = 8'ha3; // Clock rate
  localparam logic [7:0] DATA_ADDR = 8'ha4; // Shift data port
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [7:0] CTLA_RST = 8'h00;
  localparam logic [7:0] CTLB_RST = 8'he0; // Pins tri-state
  localparam logic [7:0] RATE_RST = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EAL_BIT = 7; // Global interrupt enable
  localparam int GRP_BIT = 7; // Serial group interrupt enable
  localparam int EN_BIT = 7; // Control a fields
  localparam int ON_BIT = 6;
  localparam int HALF_BIT = 5;
  localparam int TX_BIT = 4;
  localparam int MSB_BIT = 3;
  localparam int TPH_BIT = 2;
  localparam int RPH_BIT = 1;
  localparam int CIE_BIT = 0;
  localparam int DI_TRI_BIT = 7; // Control b fields
  localparam int DO_TRI_BIT = 6;
  localparam int CK_TRI_BIT = 5;
  localparam int DI_VAL_BIT = 4;
  localparam int DO_VAL_BIT = 3;
  localparam int CK_VAL_BIT = 2;
  localparam int RDY_BIT = 1;
  localparam int FLAG_BIT = 0;
  localparam int CLKP_BIT = 5; // Rate fields
  localparam int PSC_LSB = 3;
  localparam int DIV_LSB = 0;
  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam logic [4:0] EDGE_LAST = 5'h10; // Sixteen edges per cycle
  localparam logic [2:0] PSC_LIM6 = 3'h5; // Divide by six
  localparam logic [2:0] PSC_LIM3 = 3'h2;
  localparam logic [2:0] PSC_LIM2 = 3'h1;
  localparam logic [2:0] PSC_LIM1 = 3'h0;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 32;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b10
  } eng_state_t;
  typedef struct packed {
    logic o; // Driven level
    logic oe; // High while driving
  } pin_drv_t;
endpackage

// [verilog/spi_master_three_wire.sv]
/*
  Three-wire serial master with receive FIFO, register file and pins.
  Assumes one 40 MHz clock; data pins come from another domain and are
  synchronised; the testbench resolves pin wires from the enables.
*/
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Receive FIFO
// ------------------------------------------------------------------
module rx_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // Storage
  logic [AW:0] wp_r; // Write pointer, wrap bit on top
  logic [AW:0] rp_r; // Read pointer
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

// ------------------------------------------------------------------
// Serial port top
// ------------------------------------------------------------------
module spi_master_three_wire (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic irq,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic data_out_pin_i,
  output logic data_out_pin_o,
  output logic data_out_pin_oe,
  input wire logic data_in_pin_i,
  output logic data_in_pin_o,
  output logic data_in_pin_oe
);
  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0] irq_glb_r; // interrupt_enable_low
  logic [7:0] irq_grp_r; // interrupt_enable_high
  logic [7:0] ctla_r; // serial_port_control_a
  logic [7:0] ctlb_r; // serial_port_control_b, stored bits
  logic [7:0] rate_r; // serial_port_rate
  logic flag_r; // Completion flag
  logic rdy_r; // Ready for a new cycle
  spi3_pkg::eng_state_t st_r; // Engine state
  logic [4:0] edge_r; // Edges produced so far
  logic [7:0] tx_sh_r; // Transmit shifter
  logic [7:0] rx_sh_r; // Receive shifter
  logic sclk_r; // Internal serial clock level
  logic tbit_r; // Bit on the data line
  logic [2:0] pre_r; // Prescale counter
  logic [6:0] div_r; // Ratio counter
  logic di_s1, di_s2, do_s1, do_s2; // Pin synchronisers
  logic [7:0] rdata_r;
  logic irq_r;
  spi3_pkg::pin_drv_t ck_r, dq_r, di_r; // Registered pin drive

  // Decoded fields
  logic en, on, half, txdir, msb, tph, rph, cie, clkp;
  logic [1:0] psc;
  logic [2:0] dv;
  assign en = ctla_r[spi3_pkg::EN_BIT];
  assign on = ctla_r[spi3_pkg::ON_BIT];
  assign half = ctla_r[spi3_pkg::HALF_BIT];
  assign txdir = ctla_r[spi3_pkg::TX_BIT];
  assign msb = ctla_r[spi3_pkg::MSB_BIT];
  assign tph = ctla_r[spi3_pkg::TPH_BIT];
  assign rph = ctla_r[spi3_pkg::RPH_BIT];
  assign cie = ctla_r[spi3_pkg::CIE_BIT];
  assign clkp = rate_r[spi3_pkg::CLKP_BIT];
  assign psc = rate_r[spi3_pkg::PSC_LSB +: 2];
  assign dv = rate_r[spi3_pkg::DIV_LSB +: 3];

  // Bus strobes
  logic wr_data, rd_data, start;
  assign wr_data = sfr_wr && (sfr_addr == spi3_pkg::DATA_ADDR);
  assign rd_data = sfr_rd && (sfr_addr == spi3_pkg::DATA_ADDR);
  assign start = wr_data && rdy_r && en && on;

  // FIFO hookup
  logic f_in_ready, f_out_valid;
  logic [7:0] f_out_data;
  logic push;
  assign push = (st_r == spi3_pkg::ST_DONE) && f_in_ready;
  rx_fifo #(.W(spi3_pkg::FIFO_W), .D(spi3_pkg::FIFO_D)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(st_r == spi3_pkg::ST_DONE),
    .in_ready(f_in_ready),
    .in_data(rx_sh_r),
    .out_valid(f_out_valid),
    .out_ready(rd_data),
    .out_data(f_out_data)
  );

  // ----------------------------------------------------------------
  // Bit-order helpers
  // ----------------------------------------------------------------
  function automatic logic cur_bit(input logic [7:0] v, input logic m);
    cur_bit = m ? v[7] : v[0];
  endfunction
  function automatic logic [7:0] shl(input logic [7:0] v, input logic m);
    shl = m ? {v[6:0], 1'b0} : {1'b0, v[7:1]};
  endfunction

  // ----------------------------------------------------------------
  // Clock generation
  // ----------------------------------------------------------------
  logic [2:0] pre_lim;
  logic [6:0] div_lim;
  logic tick; // One serial clock edge due
  logic [4:0] enext; // Number of the edge being made
  always_comb begin
    case (psc)
      2'b00: pre_lim = spi3_pkg::PSC_LIM6;
      2'b01: pre_lim = spi3_pkg::PSC_LIM3;
      2'b10: pre_lim = spi3_pkg::PSC_LIM2;
      default: pre_lim = spi3_pkg::PSC_LIM1;
    endcase
  end
  assign div_lim = 7'((8'h01 << dv) - 8'h01);
  assign tick = (st_r == spi3_pkg::ST_RUN) && on &&
    (pre_r == pre_lim) && (div_r == div_lim);
  assign enext = edge_r + 5'h01;

  // Prescale and ratio counters, frozen in standby
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= '0;
      div_r <= '0;
    end else if (start || st_r != spi3_pkg::ST_RUN) begin
      pre_r <= '0;
      div_r <= '0;
    end else if (on) begin
      if (pre_r == pre_lim) begin
        pre_r <= '0;
        div_r <= (div_r == div_lim) ? 7'h00 : div_r + 7'h01;
      end else begin
        pre_r <= pre_r + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      di_s1 <= 1'b0;
      di_s2 <= 1'b0;
      do_s1 <= 1'b0;
      do_s2 <= 1'b0;
    end else begin
      di_s1 <= data_in_pin_i;
      di_s2 <= di_s1;
      do_s1 <= data_out_pin_i;
      do_s2 <= do_s1;
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  logic rx_src;
  assign rx_src = half ? do_s2 : di_s2;

  // State, edge count and serial clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= spi3_pkg::ST_IDLE;
      edge_r <= '0;
      sclk_r <= 1'b0;
    end else begin
      case (st_r)
        spi3_pkg::ST_IDLE: begin
          sclk_r <= clkp;
          edge_r <= '0;
          if (start) begin
            st_r <= spi3_pkg::ST_RUN;
          end
        end
        spi3_pkg::ST_RUN: begin
          if (!en) begin
            st_r <= spi3_pkg::ST_IDLE; // Abort on disable
          end else if (tick) begin
            sclk_r <= ~sclk_r;
            edge_r <= enext;
            if (enext == spi3_pkg::EDGE_LAST) begin
              st_r <= spi3_pkg::ST_DONE;
            end
          end
        end
        spi3_pkg::ST_DONE: begin
          sclk_r <= clkp;
          if (push) begin // Waits while FIFO is full
            st_r <= spi3_pkg::ST_IDLE;
          end
        end
        default: st_r <= spi3_pkg::ST_IDLE;
      endcase
    end
  end

  // Transmit shifter, launch per transmit phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_r <= '0;
      tbit_r <= 1'b0;
    end else if (start) begin
      if (tph) begin
        tx_sh_r <= sfr_wdata; // First bit at edge one
      end else begin
        tbit_r <= cur_bit(sfr_wdata, msb); // Before edge one
        tx_sh_r <= shl(sfr_wdata, msb);
      end
    end else if (tick && (tph ? enext[0] :
               (!enext[0] && enext != spi3_pkg::EDGE_LAST))) begin
      tbit_r <= cur_bit(tx_sh_r, msb);
      tx_sh_r <= shl(tx_sh_r, msb);
    end
  end

  // Receive shifter, sampling per receive phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_r <= '0;
    end else if (tick && (rph ? !enext[0] : enext[0])) begin
      rx_sh_r <= msb ? {rx_sh_r[6:0], rx_src}
                     : {rx_src, rx_sh_r[7:1]};
    end
  end

  // Ready bit and completion flag; set beats clear
  logic flag_clr;
  assign flag_clr = sfr_wr && (sfr_addr == spi3_pkg::CTLB_ADDR) &&
    sfr_wdata[spi3_pkg::FLAG_BIT];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_r <= 1'b1;
      flag_r <= 1'b0;
    end else begin
      if (push) begin
        rdy_r <= 1'b1;
        flag_r <= 1'b1;
      end else begin
        if (start) begin
          rdy_r <= 1'b0;
        end else if (st_r == spi3_pkg::ST_RUN && !en) begin
          rdy_r <= 1'b1;
        end
        if (flag_clr) begin
          flag_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_glb_r <= spi3_pkg::IEN_RST;
      irq_grp_r <= spi3_pkg::IEN_RST;
      ctla_r <= spi3_pkg::CTLA_RST;
      ctlb_r <= spi3_pkg::CTLB_RST;
      rate_r <= spi3_pkg::RATE_RST;
    end else if (sfr_wr) begin
      case (sfr_addr)
        spi3_pkg::IRQ_GLB_ADDR: irq_glb_r <= sfr_wdata;
        spi3_pkg::IRQ_GRP_ADDR: irq_grp_r <= sfr_wdata;
        spi3_pkg::CTLA_ADDR: ctla_r <= sfr_wdata;
        spi3_pkg::CTLB_ADDR: ctlb_r <= {sfr_wdata[7:2], 2'b00};
        spi3_pkg::RATE_ADDR: rate_r <= {2'b00, sfr_wdata[5:0]};
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe; data read pops the FIFO
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (sfr_rd) begin
      case (sfr_addr)
        spi3_pkg::IRQ_GLB_ADDR: rdata_r <= irq_glb_r;
        spi3_pkg::IRQ_GRP_ADDR: rdata_r <= irq_grp_r;
        spi3_pkg::CTLA_ADDR: rdata_r <= ctla_r;
        spi3_pkg::CTLB_ADDR: rdata_r <= {ctlb_r[7:2], rdy_r, flag_r};
        spi3_pkg::RATE_ADDR: rdata_r <= rate_r;
        spi3_pkg::DATA_ADDR: rdata_r <= f_out_valid ? f_out_data
                                                    : 8'h00;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  // Interrupt request through local, group and global enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= flag_r && cie && irq_grp_r[spi3_pkg::GRP_BIT] &&
        irq_glb_r[spi3_pkg::EAL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_r <= '0;
      dq_r <= '0;
      di_r <= '0;
    end else if (en) begin
      ck_r <= '{o: sclk_r, oe: 1'b1};
      dq_r <= '{o: tbit_r, oe: !half || txdir};
      di_r <= half ? '{o: ctlb_r[spi3_pkg::DI_VAL_BIT],
                       oe: !ctlb_r[spi3_pkg::DI_TRI_BIT]}
                   : '{o: 1'b0, oe: 1'b0};
    end else begin
      ck_r <= '{o: ctlb_r[spi3_pkg::CK_VAL_BIT],
                oe: !ctlb_r[spi3_pkg::CK_TRI_BIT]};
      dq_r <= '{o: ctlb_r[spi3_pkg::DO_VAL_BIT],
                oe: !ctlb_r[spi3_pkg::DO_TRI_BIT]};
      di_r <= '{o: ctlb_r[spi3_pkg::DI_VAL_BIT],
                oe: !ctlb_r[spi3_pkg::DI_TRI_BIT]};
    end
  end

  assign sfr_rdata = rdata_r;
  assign irq = irq_r;
  assign sclk_o = ck_r.o;
  assign sclk_oe = ck_r.oe;
  assign data_out_pin_o = dq_r.o;
  assign data_out_pin_oe = dq_r.oe;
  assign data_in_pin_o = di_r.o;
  assign data_in_pin_oe = di_r.oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_start_busy: assert property (start |=> !rdy_r &&
    st_r == spi3_pkg::ST_RUN) else $error("start not taken");
  chk_busy_ignore: assert property (
    (wr_data && st_r == spi3_pkg::ST_RUN && !tick) |=> $stable(tx_sh_r))
    else $error("busy write disturbed shifter");
  chk_edge_bound: assert property (edge_r <= spi3_pkg::EDGE_LAST)
    else $error("edge count overrun");
  chk_clock_toggle: assert property (
    (tick && en) |=> sclk_r != $past(sclk_r)) else $error("no edge");
  chk_idle_level: assert property (
    (st_r == spi3_pkg::ST_IDLE && $past(st_r) == spi3_pkg::ST_IDLE)
    |-> sclk_r == $past(clkp)) else $error("clock not idle");
  chk_flag_ready: assert property (push |=> flag_r && rdy_r)
    else $error("completion not flagged");
  chk_irq_gate: assert property (irq_r |->
    $past(flag_r && irq_glb_r[spi3_pkg::EAL_BIT])) else $error("stray irq");
  chk_standby_gate: assert property (!on |-> !tick)
    else $error("tick in standby");
  chk_busy_ready: assert property (
    st_r == spi3_pkg::ST_RUN |-> !rdy_r) else $error("ready while busy");
  chk_gpio_drive: assert property (!en |=>
    sclk_oe == !$past(ctlb_r[spi3_pkg::CK_TRI_BIT]))
    else $error("gpio enable wrong");

  cov_full_cycle: cover property (start ##[1:1000] push);
  cov_half_cycle: cover property ((start && half) ##[1:1000] push);
  cov_fifo_full: cover property (st_r == spi3_pkg::ST_DONE && !f_in_ready);
endmodule

`default_nettype wire

// [tb/spi_periph.sv]
/*
  Behavioural serial peripheral on the far side of the port.
  Assumes the bench holds clr high outside transfers and low within.
*/
`timescale 1ns/10ps
`default_nettype none
module spi_periph (
  input wire logic sclk,
  input wire logic sdi,
  input wire logic clr,
  input wire logic tph,
  input wire logic rph,
  input wire logic msb,
  input wire logic [7:0] tx_byte,
  output logic sdo,
  output logic [7:0] rx_byte
);
  int e; // Edges seen in this word
  int j; // Capture bit index
  logic [7:0] cap; // Capture shifter
  function automatic logic pick(input logic [7:0] b, input int i,
                                input logic m);
    return m ? b[7-i] : b[i];
  endfunction
  // Line idles low before the first word
  initial sdo = 1'b0;
  // Start of word: first bit early, or a released line
  always @(negedge clr) begin
    e = 0;
    sdo = rph ? ~sdo : pick(tx_byte, 0, msb);
  end
  // Capture and launch on each clock edge
  always @(sclk) begin
    if (!clr && e < 16) begin
      e++;
      if (tph ? e % 2 == 0 : e % 2 == 1) begin
        j = tph ? e / 2 - 1 : (e - 1) / 2;
        cap[msb ? 7 - j : j] = sdi;
      end
      if (e == 16) begin
        rx_byte = cap;
        sdo = ~sdo; // Released after the last edge
      end else if (rph ? e % 2 == 1 : e % 2 == 0) begin
        sdo = pick(tx_byte, rph ? (e - 1) / 2 : e / 2, msb);
      end
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
/*
  Self-checking bench for the three-wire serial port.
  Assumes the design package and the peripheral model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [7:0] A_CA = spi3_pkg::CTLA_ADDR;
  localparam logic [7:0] A_CB = spi3_pkg::CTLB_ADDR;
  localparam logic [7:0] A_RT = spi3_pkg::RATE_ADDR;
  localparam logic [7:0] A_DT = spi3_pkg::DATA_ADDR;
  localparam logic [7:0] A_I0 = spi3_pkg::IRQ_GLB_ADDR;
  localparam logic [7:0] A_I1 = spi3_pkg::IRQ_GRP_ADDR;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, clr = 1, half = 0;
  logic tph = 0, rph = 0, msb = 0;
  logic [7:0] addr = 0, wdata = 0, ptx = 0, v, rdata, prx;
  logic sclk_o, sclk_oe, do_o, do_oe, di_o, di_oe, irq, sdo;
  logic sclk_w, do_w, di_w;
  int n_mismatch = 0, tests_run = 0, n_edge = 0, i, m;
  realtime t_prev = 0, t_last = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Pin wires: pull-up where nobody drives
  assign sclk_w = sclk_oe ? sclk_o : 1'b1;
  assign do_w = do_oe ? do_o : (half ? sdo : 1'b1);
  assign di_w = di_oe ? di_o : (half ? 1'b1 : sdo);
  // Edge counter and spacing on the clock wire
  always @(sclk_w) begin
    n_edge++;
    t_prev = t_last;
    t_last = $realtime;
  end
  spi_master_three_wire i_dut (.clk(clk), .rst_n(rst_n),
    .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata),
    .sfr_rdata(rdata), .irq(irq), .sclk_i(sclk_w), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe), .data_out_pin_i(do_w), .data_out_pin_o(do_o),
    .data_out_pin_oe(do_oe), .data_in_pin_i(di_w),
    .data_in_pin_o(di_o), .data_in_pin_oe(di_oe));
  spi_periph i_per (.sclk(sclk_w), .sdi(do_w), .clr(clr), .tph(tph),
    .rph(rph), .msb(msb), .tx_byte(ptx), .sdo(sdo), .rx_byte(prx));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s %h/%h", $time, what, got, exp);
    end
  endtask
  task automatic check_n(input int got, exp, input string what);
    tests_run++;
    if (got != exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s %0d/%0d", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    d = rdata;
  endtask
  // Poll the ready bit under a bound
  task automatic wait_rdy;
    int k;
    for (k = 0; k < 4000; k++) begin
      rd_reg(A_CB, v);
      if (v[1] === 1'b1) break;
    end
    check(v[1], 1'b1, "ready");
  endtask
  // Start one word without waiting
  task automatic start(input logic [7:0] t, p);
    ptx = p;
    repeat (2) @(negedge clk);
    n_edge = 0;
    clr = 0;
    wr_reg(A_DT, t);
  endtask
  task automatic xfer(input logic [7:0] t, p);
    start(t, p);
    wait_rdy;
    clr = 1;
  endtask
  task automatic pins(input logic [5:0] exp);
    repeat (2) @(negedge clk);
    check({sclk_oe, do_oe, di_oe, sclk_o, do_o, di_o}, exp, "pins");
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  // Watchdog: whole run needs some 8k cycles
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    give_verdict;
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1;
    // Reset values, ready set, unmapped address reads zero
    rd_reg(A_CA, v); check(v, 8'h00, "ctla");
    rd_reg(A_CB, v); check(v, 8'he2, "ctlb");
    rd_reg(A_RT, v); check(v, 8'h00, "rate");
    rd_reg(A_I0, v); check(v, 8'h00, "interrupt_enable_low");
    rd_reg(A_I1, v); check(v, 8'h00, "interrupt_enable_high");
    rd_reg(8'h55, v); check(v, 8'h00, "unmapped");
    done("reset");
    // Released pins: outputs with values, then tri-state
    wr_reg(A_CB, 8'h14); pins(6'b111_101);
    wr_reg(A_CB, 8'h08); pins(6'b111_010);
    wr_reg(A_CB, 8'he0); pins(6'b000_000);
    done("gpio");
    // Phase, order and polarity combinations
    for (m = 0; m < 4; m++) begin
      tph = m[0]; rph = m[1]; msb = m[0] ^ m[1];
      wr_reg(A_RT, {2'b00, m[1], 5'h00});
      wr_reg(A_CA, {4'b1100, msb, tph, rph, 1'b0});
      repeat (2) @(negedge clk);
      check({sclk_oe, do_oe, sclk_w}, {2'b11, m[1]}, "idle");
      xfer(8'h1d + m, 8'hc4 ^ m);
      check(prx, 8'h1d + m, "peripheral rx");
      check_n(n_edge, 16, "edges");
      check(sclk_w, m[1], "clock idle after");
      rd_reg(A_DT, v); check(v, 8'hc4 ^ m, "rx data");
      rd_reg(A_CB, v); check(v[0], 1'b1, "flag set");
      wr_reg(A_CB, 8'he1);
      rd_reg(A_CB, v); check(v[0], 1'b0, "flag clear");
    end
    done("modes");
    // Edge spacing for prescale and ratio codes
    for (m = 0; m < 4; m++) begin
      v = {8'h18, 8'h00, 8'h1c, 8'hff} >> (8 * m);
      wr_reg(A_RT, v);
      xfer(8'h00, 8'h00);
      check_n(int'((t_last - t_prev) / 25.0),
              (m == 0) ? 128 : (m == 1) ? 16 : (m == 2) ? 6 : 1,
              "spacing");
      rd_reg(A_DT, v);
    end
    wr_reg(A_RT, 8'h00);
    done("rates");
    // Busy write ignored, ready low while running
    start(8'ha5, 8'h00);
    rd_reg(A_CB, v); check(v[1], 1'b0, "busy");
    wr_reg(A_DT, 8'h3c);
    wait_rdy;
    repeat (300) @(negedge clk);
    clr = 1;
    check(prx, 8'ha5, "first word kept");
    check_n(n_edge, 16, "no restart");
    rd_reg(A_DT, v);
    done("busy");
    // Interrupt gating by flag and three enables
    wr_reg(A_CA, 8'hc1); wr_reg(A_I0, 8'h80); wr_reg(A_I1, 8'h80);
    wr_reg(A_CB, 8'he1);
    xfer(8'h77, 8'h00);
    pins({3'b110, 3'b000} | {sclk_oe, do_oe, di_oe, sclk_o, do_o, di_o});
    check(irq, 1'b1, "irq");
    wr_reg(A_I1, 8'h00); pins(6'b110_000); check(irq, 1'b0, "group");
    wr_reg(A_I1, 8'h80); wr_reg(A_I0, 8'h00);
    repeat (2) @(negedge clk); check(irq, 1'b0, "global");
    wr_reg(A_I0, 8'h80); wr_reg(A_CA, 8'hc0);
    repeat (2) @(negedge clk); check(irq, 1'b0, "ie off");
    wr_reg(A_CA, 8'hc1);
    repeat (2) @(negedge clk); check(irq, 1'b1, "ie on");
    wr_reg(A_CB, 8'he1);
    repeat (2) @(negedge clk); check(irq, 1'b0, "cleared");
    rd_reg(A_DT, v);
    done("irq");
    // Half duplex send, then receive with a dummy write
    half = 1; tph = 0; rph = 0; msb = 1;
    wr_reg(A_CA, 8'hf8); wr_reg(A_CB, 8'h70);
    repeat (2) @(negedge clk);
    check({di_oe, di_o}, 2'b11, "free data-in");
    xfer(8'h96, 8'h00);
    check(prx, 8'h96, "half send");
    rd_reg(A_DT, v); check(v, 8'h96, "own line");
    wr_reg(A_CA, 8'he8);
    repeat (2) @(negedge clk); check(do_oe, 1'b0, "input");
    xfer(8'hff, 8'h5a);
    rd_reg(A_DT, v); check(v, 8'h5a, "half receive");
    half = 0; msb = 0;
    wr_reg(A_CB, 8'he0);
    done("half");
    // Standby: data write starts nothing
    wr_reg(A_CA, 8'h80);
    start(8'h12, 8'h00);
    repeat (100) @(negedge clk);
    clr = 1;
    check_n(n_edge, 0, "standby edges");
    done("standby");
    // Fill the receive buffer until the engine stalls, then drain
    wr_reg(A_CA, 8'hc0);
    for (i = 0; i < 32; i++) xfer(8'h00, i[7:0] ^ 8'h5a);
    start(8'h00, 8'hee);
    repeat (300) @(negedge clk);
    rd_reg(A_CB, v); check(v[1], 1'b0, "stalled");
    for (i = 0; i < 32; i++) begin
      rd_reg(A_DT, v); check(v, i[7:0] ^ 8'h5a, "drain");
    end
    wait_rdy;
    clr = 1;
    rd_reg(A_DT, v); check(v, 8'hee, "last word");
    rd_reg(A_DT, v); check(v, 8'h00, "empty");
    done("fifo");
    give_verdict;
  end
endmodule
`default_nettype wire
